// ### cme_defs.svh
// constants of the command mode escape block
`ifndef CME_DEFS_SVH
`define CME_DEFS_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define CME_CODE_PRE_GUARD  8'h04
`define CME_CODE_POST_GUARD 8'h05
`define CME_CODE_TIMEOUT    8'h06
`define CME_CODE_EXIT       8'h09
`define CME_CODE_ESC_CHAR   8'h13
`define CME_CODE_FLOW_CFG   8'h1F
`define CME_CODE_IND_CFG    8'h28

// ----------------------------------------------------------------
// reset values and ranges
// ----------------------------------------------------------------
`define CME_PRE_GUARD_RST   16'h000A
`define CME_POST_GUARD_RST  16'h000A
`define CME_TIMEOUT_RST     16'h00C8
`define CME_ESC_CHAR_RST    8'h2B
`define CME_FLOW_CFG_RST    8'h00
`define CME_IND_CFG_RST     8'h00
`define CME_GUARD_MIN       16'h0002
`define CME_ESC_MIN         8'h20
`define CME_ESC_MAX         8'h7F
`define CME_FLOW_CFG_MAX    8'h04
`define CME_IND_CFG_MAX     8'h03
`define CME_ESC_REPEAT      2'h3
`define CME_SILENCE_MAX     16'hFFFF

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CME_TICK_MS         100
`define CME_CLK_KHZ         200000
`define CME_TICK_CYCLES     (`CME_TICK_MS * `CME_CLK_KHZ)

`endif

// ### cme_host.sv
// host processor model on the serial side of the escape block
`timescale 1ns/1ps
`default_nettype none
module cme_host (
  input  wire logic                  clock_in,     // clock
  input  wire logic                  tx_valid_in,  // reply valid
  input  wire logic [7:0]            tx_byte_in,   // reply byte
  output var  logic                  rx_valid_out, // byte strobe
  output var  cme_pkg::cme_byte_type rx_out,       // byte value
  output var  logic                  tx_ready_out  // reply taken
);
  int         seed = 58931;
  logic [7:0] got[$];
  initial begin
    rx_valid_out = 1'b0;
    rx_out = '0;
    tx_ready_out = 1'b0;
  end
  // takes reply bytes with random stalls
  always @(posedge clock_in) begin
    if (tx_valid_in && tx_ready_out)
      got.push_back(tx_byte_in);
    tx_ready_out <= 1'($random(seed));
  end
  // one byte, then at least four idle cycles
  task automatic send(input logic [7:0] d, input logic l);
    rx_out <= '{last: l, data: d};
    rx_valid_out <= 1'b1;
    @(posedge clock_in);
    rx_valid_out <= 1'b0;
    rx_out <= ~rx_out;
    repeat (4) @(posedge clock_in);
  endtask : send
endmodule : cme_host
`default_nettype wire

// ### cme_pkg.sv
// types of the command mode escape block
`default_nettype none
package cme_pkg;

  typedef enum logic [1:0] {
    CME_DATA,
    CME_ESC,
    CME_CMD
  } cme_mode_type;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } cme_byte_type;

  typedef struct packed {
    logic [2:0]   sync;
    logic         pin_level;
    cme_mode_type mode;
    logic [1:0]   esc_cnt;
    logic [15:0]  silence;
    logic [15:0]  pre_guard;
    logic [15:0]  post_guard;
    logic [15:0]  timeout;
    logic [7:0]   esc_char;
    logic [7:0]   flow_cfg;
    logic [7:0]   ind_cfg;
    logic         have_code;
    logic [7:0]   code;
    logic [15:0]  acc;
    logic [1:0]   replay_cnt;
    logic         stash_valid;
    logic [7:0]   stash;
    logic         data_valid;
    logic [7:0]   data_byte;
    logic [1:0]   tx_cnt;
    logic [15:0]  tx_data;
    logic         flow_pin;
    logic         ind_pin;
  } cme_state_type;

  typedef struct packed {
    logic [24:0] count;
    logic        tick;
  } cme_tick_state_type;

endpackage : cme_pkg
`default_nettype wire

// ### cme_sva.sv
// assertion checker of the command mode escape block
`timescale 1ns/1ps
`default_nettype none
module cme_sva #(
  parameter int TICK_CYCLES = 20
) (
  input wire logic                  clock_in,        // clock
  input wire logic                  nrst_in,         // reset, low
  input wire logic                  rx_valid_in,     // byte strobe
  input wire cme_pkg::cme_byte_type rx_in,           // byte value
  input wire logic                  tx_ready_in,     // reply taken
  input wire logic                  tx_valid_out,    // reply valid
  input wire logic [7:0]            tx_byte_out,     // reply byte
  input wire logic                  data_valid_out,  // data strobe
  input wire logic [7:0]            data_byte_out,   // data byte
  input wire logic                  command_mode_out // command mode
);
  logic [31:0] quiet;
  logic        code_pos;
  logic        q_exit;
  logic        q_query;
  wire logic   hit = command_mode_out && rx_valid_in && code_pos;
  // cycles since a byte, code position, last byte kinds
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      quiet <= 32'h0;
      code_pos <= 1'b1;
      q_exit <= 1'b0;
      q_query <= 1'b0;
    end else begin
      quiet <= rx_valid_in ? 32'h0 : quiet + 32'h1;
      code_pos <= !command_mode_out || (rx_valid_in ? rx_in.last : code_pos);
      q_exit <= hit && rx_in.data == 8'h09;
      q_query <= command_mode_out && rx_valid_in && rx_in.last;
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  a_entry_after_quiet: assert property (
    $rose(command_mode_out) |-> quiet + 4 >= 2 * TICK_CYCLES)
    else $error("command mode entered without silence");
  a_exit_on_code: assert property (
    hit && rx_in.data == 8'h09 |=> !command_mode_out)
    else $error("exit code ignored");
  a_exit_cause: assert property (
    $fell(command_mode_out) |-> q_exit || quiet + 4 >= 2 * TICK_CYCLES)
    else $error("command mode left without cause");
  a_query_reply: assert property (
    hit && rx_in.last && rx_in.data inside {8'h04, 8'h05, 8'h06,
    8'h13, 8'h1F, 8'h28} |=> tx_valid_out)
    else $error("query got no reply");
  a_reply_cause: assert property (
    $rose(tx_valid_out) |-> q_query)
    else $error("reply without query");
  a_reply_hold: assert property (
    tx_valid_out && !tx_ready_in && !rx_valid_in
    |=> tx_valid_out && $stable(tx_byte_out))
    else $error("reply byte dropped");
  a_cmd_no_data: assert property (
    command_mode_out |-> !data_valid_out)
    else $error("data passed in command mode");
  a_plain_pass: assert property (
    !command_mode_out && rx_valid_in && rx_in.data == 8'h41
    |-> ##[1:4] data_valid_out && data_byte_out == 8'h41)
    else $error("plain byte not passed");
endmodule : cme_sva
bind cme_top cme_sva #(.TICK_CYCLES(TICK_CYCLES)) u_cme_sva (
  .clock_in(clock_in), .nrst_in(nrst_in), .rx_valid_in(rx_valid_in),
  .rx_in(rx_in), .tx_ready_in(tx_ready_in), .tx_valid_out(tx_valid_out),
  .tx_byte_out(tx_byte_out), .data_valid_out(data_valid_out),
  .data_byte_out(data_byte_out), .command_mode_out(command_mode_out));
`default_nettype wire

// ### cme_tick.sv
// 100 ms tick generator, restarted by line activity
`timescale 1ns/1ps
`default_nettype none
module cme_tick #(
  parameter int TICK_CYCLES = 20000000
) (
  input  wire logic clock_in,   // module clock
  input  wire logic nrst_in,    // async reset, active low
  input  wire logic restart_in, // restart the period
  output logic      tick_out    // one-cycle pulse per period
);
  cme_pkg::cme_tick_state_type s;
  cme_pkg::cme_tick_state_type next_s;

  // counter holds up to 2**25 cycles per period
  if (TICK_CYCLES < 2 || TICK_CYCLES > 33554432) begin : g_bad_ticks
    $error("cme_tick: TICK_CYCLES out of range");
  end

  localparam logic [24:0] LAST = 25'(TICK_CYCLES - 1);

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (restart_in) begin
      next_s.count = 25'h0000000;
    end else if (s.count == LAST) begin
      next_s.count = 25'h0000000;
      next_s.tick = 1'b1;
    end else begin
      next_s.count = s.count + 25'h0000001;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick_out = s.tick;
endmodule : cme_tick
`default_nettype wire

// ### cme_top.sv
// escape detection, command mode settings and auxiliary output pins
`timescale 1ns/1ps
`default_nettype none
`include "cme_defs.svh"
module cme_top #(
  parameter int TICK_CYCLES = `CME_TICK_CYCLES
) (
  input  wire logic                clock_in,          // 200 MHz clock
  input  wire logic                nrst_in,           // async reset, low
  input  wire logic                serial_input_pin,  // raw data-in pin
  input  wire logic                rx_valid_in,       // received byte
  input  wire cme_pkg::cme_byte_type rx_in,           // byte and line end
  input  wire logic                tx_ready_in,       // reply consumer
  input  wire logic                clear_to_send_in,  // room for data
  input  wire logic                tx_active_in,      // line driver busy
  input  wire logic                receive_indicator, // rf packet seen
  output logic                     data_valid_out,    // idle data byte
  output logic [7:0]               data_byte_out,     // idle data value
  output logic                     tx_valid_out,      // reply byte valid
  output logic [7:0]               tx_byte_out,       // reply byte
  output logic                     command_mode_out,  // in command mode
  output logic                     flow_output_pin,   // flow pin level
  output logic                     indicator_output_pin // indicator pin
);
  cme_pkg::cme_state_type s;
  cme_pkg::cme_state_type next_s;
  logic                   tick;
  logic                   pin_change;
  logic                   activity;
  logic                   is_esc;

  if (TICK_CYCLES < 2) begin : g_bad_ticks
    $error("cme_top: TICK_CYCLES below 2");
  end

  // ----------------------------------------------------------------
  // silence timebase
  // ----------------------------------------------------------------
  assign pin_change = (s.sync[1] == s.sync[2]) && (s.sync[2] != s.pin_level);
  assign activity   = rx_valid_in || pin_change;
  assign is_esc     = rx_in.data == s.esc_char;

  cme_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clock_in   (clock_in),
    .nrst_in    (nrst_in),
    .restart_in (activity),
    .tick_out   (tick)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.sync = {s.sync[1:0], serial_input_pin};
    if (pin_change) begin
      next_s.pin_level = s.sync[2];
    end
    if (activity) begin
      next_s.silence = 16'h0000;
    end else if (tick && s.silence != `CME_SILENCE_MAX) begin
      next_s.silence = s.silence + 16'h0001;
    end

    // replay of held escape bytes, then the stashed byte
    next_s.data_valid = 1'b0;
    if (s.replay_cnt != 2'h0) begin
      next_s.data_valid = 1'b1;
      next_s.data_byte = s.esc_char;
      next_s.replay_cnt = s.replay_cnt - 2'h1;
    end else if (s.stash_valid) begin
      next_s.data_valid = 1'b1;
      next_s.data_byte = s.stash;
      next_s.stash_valid = 1'b0;
    end

    // reply shifter, high byte first
    if (s.tx_cnt != 2'h0 && tx_ready_in) begin
      next_s.tx_cnt = s.tx_cnt - 2'h1;
      next_s.tx_data = {s.tx_data[7:0], 8'h00};
    end

    case (s.mode)
      cme_pkg::CME_DATA: begin
        if (rx_valid_in) begin
          if (is_esc && s.silence >= s.pre_guard) begin
            next_s.mode = cme_pkg::CME_ESC;
            next_s.esc_cnt = 2'h1;
          end else begin
            next_s.data_valid = 1'b1;
            next_s.data_byte = rx_in.data;
          end
        end
      end
      cme_pkg::CME_ESC: begin
        if (rx_valid_in) begin
          if (is_esc && s.esc_cnt < `CME_ESC_REPEAT) begin
            next_s.esc_cnt = s.esc_cnt + 2'h1;
          end else begin
            next_s.mode = cme_pkg::CME_DATA;
            next_s.replay_cnt = s.esc_cnt;
            next_s.stash = rx_in.data;
            next_s.stash_valid = 1'b1;
          end
        end else if (s.silence >= s.post_guard) begin
          if (s.esc_cnt == `CME_ESC_REPEAT) begin
            next_s.mode = cme_pkg::CME_CMD;
            next_s.have_code = 1'b0;
          end else begin
            next_s.mode = cme_pkg::CME_DATA;
            next_s.replay_cnt = s.esc_cnt;
          end
        end
      end
      cme_pkg::CME_CMD: begin
        if (rx_valid_in && !s.have_code) begin
          next_s.code = rx_in.data;
          next_s.acc = 16'h0000;
          if (rx_in.data == `CME_CODE_EXIT) begin
            next_s.mode = cme_pkg::CME_DATA;
          end else if (rx_in.last) begin
            case (rx_in.data)
              `CME_CODE_PRE_GUARD: begin
                next_s.tx_cnt = 2'h2;
                next_s.tx_data = s.pre_guard;
              end
              `CME_CODE_POST_GUARD: begin
                next_s.tx_cnt = 2'h2;
                next_s.tx_data = s.post_guard;
              end
              `CME_CODE_TIMEOUT: begin
                next_s.tx_cnt = 2'h2;
                next_s.tx_data = s.timeout;
              end
              `CME_CODE_ESC_CHAR: begin
                next_s.tx_cnt = 2'h1;
                next_s.tx_data = {s.esc_char, 8'h00};
              end
              `CME_CODE_FLOW_CFG: begin
                next_s.tx_cnt = 2'h1;
                next_s.tx_data = {s.flow_cfg, 8'h00};
              end
              `CME_CODE_IND_CFG: begin
                next_s.tx_cnt = 2'h1;
                next_s.tx_data = {s.ind_cfg, 8'h00};
              end
              default: begin
              end
            endcase
          end else begin
            next_s.have_code = 1'b1;
          end
        end else if (rx_valid_in) begin
          next_s.acc = {s.acc[7:0], rx_in.data};
          if (rx_in.last) begin
            next_s.have_code = 1'b0;
            case (s.code)
              `CME_CODE_PRE_GUARD: begin
                if ({s.acc[7:0], rx_in.data} >= `CME_GUARD_MIN) begin
                  next_s.pre_guard = {s.acc[7:0], rx_in.data};
                end
              end
              `CME_CODE_POST_GUARD: begin
                if ({s.acc[7:0], rx_in.data} >= `CME_GUARD_MIN) begin
                  next_s.post_guard = {s.acc[7:0], rx_in.data};
                end
              end
              `CME_CODE_TIMEOUT: begin
                if ({s.acc[7:0], rx_in.data} >= `CME_GUARD_MIN) begin
                  next_s.timeout = {s.acc[7:0], rx_in.data};
                end
              end
              `CME_CODE_ESC_CHAR: begin
                if (rx_in.data >= `CME_ESC_MIN &&
                    rx_in.data <= `CME_ESC_MAX) begin
                  next_s.esc_char = rx_in.data;
                end
              end
              `CME_CODE_FLOW_CFG: begin
                if (rx_in.data <= `CME_FLOW_CFG_MAX) begin
                  next_s.flow_cfg = rx_in.data;
                end
              end
              `CME_CODE_IND_CFG: begin
                if (rx_in.data <= `CME_IND_CFG_MAX) begin
                  next_s.ind_cfg = rx_in.data;
                end
              end
              default: begin
              end
            endcase
          end
        end else if (s.silence >= s.timeout) begin
          next_s.mode = cme_pkg::CME_DATA;
          next_s.have_code = 1'b0;
        end
      end
      default: begin
        next_s.mode = cme_pkg::CME_DATA;
      end
    endcase

    // ----------------------------------------------------------------
    // auxiliary pins
    // ----------------------------------------------------------------
    case (s.flow_cfg)
      8'h00: next_s.flow_pin = ~clear_to_send_in;
      8'h01: next_s.flow_pin = ~tx_active_in;
      8'h02: next_s.flow_pin = 1'b1;
      8'h03: next_s.flow_pin = tx_active_in;
      8'h04: next_s.flow_pin = 1'b0;
      default: next_s.flow_pin = 1'b0;
    endcase
    case (s.ind_cfg)
      8'h00: next_s.ind_pin = receive_indicator;
      8'h01: next_s.ind_pin = 1'b1;
      8'h02: next_s.ind_pin = 1'b0;
      default: next_s.ind_pin = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s <= '0;
      s.sync <= 3'h7;
      s.pin_level <= 1'b1;
      s.mode <= cme_pkg::CME_DATA;
      s.pre_guard <= `CME_PRE_GUARD_RST;
      s.post_guard <= `CME_POST_GUARD_RST;
      s.timeout <= `CME_TIMEOUT_RST;
      s.esc_char <= `CME_ESC_CHAR_RST;
      s.flow_cfg <= `CME_FLOW_CFG_RST;
      s.ind_cfg <= `CME_IND_CFG_RST;
      s.flow_pin <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign data_valid_out       = s.data_valid;
  assign data_byte_out        = s.data_byte;
  assign tx_valid_out         = s.tx_cnt != 2'h0;
  assign tx_byte_out          = s.tx_data[15:8];
  assign command_mode_out     = s.mode == cme_pkg::CME_CMD;
  assign flow_output_pin      = s.flow_pin;
  assign indicator_output_pin = s.ind_pin;
endmodule : cme_top
`default_nettype wire

// ### cme_top_placeholder_none.sv
// intentionally empty module-free file
`default_nettype none
`default_nettype wire

// ### cme_top_test.sv
// self-checking testbench of the command mode escape block
`timescale 1ns/1ps
`default_nettype none
module cme_top_test;
  localparam int TICK = 20;
  logic                  clock_in = 1'b0;
  logic                  nrst_in = 1'b0;
  logic                  cts = 1'b0;
  logic                  txa = 1'b0;
  logic                  ind = 1'b0;
  logic                  din = 1'b1;
  logic                  rx_valid, tx_ready, tx_valid, data_valid, cmd;
  logic                  flow_pin, ind_pin;
  logic [7:0]            tx_byte, data_byte;
  cme_pkg::cme_byte_type rx;
  logic [7:0]            dq[$];
  int                    errors = 0;
  int                    num_checks = 0;
  int                    seed = 58931;
  int                    k, i;
  logic [7:0]  codes[6] = '{8'h04, 8'h05, 8'h06, 8'h13, 8'h1F, 8'h28};
  logic [15:0] rv[6] = '{16'h000A, 16'h000A, 16'h00C8, 16'h002B, 16'h0, 16'h0};
  always #2.5 clock_in = ~clock_in;
  cme_top #(.TICK_CYCLES(TICK)) u_cme_top (
    .clock_in(clock_in), .nrst_in(nrst_in), .serial_input_pin(din),
    .rx_valid_in(rx_valid), .rx_in(rx), .tx_ready_in(tx_ready),
    .clear_to_send_in(cts), .tx_active_in(txa), .receive_indicator(ind),
    .data_valid_out(data_valid), .data_byte_out(data_byte),
    .tx_valid_out(tx_valid), .tx_byte_out(tx_byte),
    .command_mode_out(cmd), .flow_output_pin(flow_pin),
    .indicator_output_pin(ind_pin));
  cme_host u_host (
    .clock_in(clock_in), .tx_valid_in(tx_valid), .tx_byte_in(tx_byte),
    .rx_valid_out(rx_valid), .rx_out(rx), .tx_ready_out(tx_ready));
  always @(posedge clock_in) if (data_valid) dq.push_back(data_byte);
  function automatic logic flow_exp(input int c, input logic s, a);
    case (c)
      0: return ~s;
      1: return ~a;
      2: return 1'b1;
      3: return a;
      default: return 1'b0;
    endcase
  endfunction : flow_exp
  task automatic check(input string n, input logic [15:0] e, g);
    num_checks++;
    if (e !== g) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask : cyc
  task automatic wr(input logic [7:0] c, input logic [15:0] v, input bit two);
    u_host.send(c, 1'b0);
    if (two) u_host.send(v[15:8], 1'b0);
    u_host.send(v[7:0], 1'b1);
  endtask : wr
  task automatic query(input logic [7:0] c, input int n, input logic [15:0] e);
    u_host.got.delete();
    u_host.send(c, 1'b1);
    #1;
    for (int j = 0; j < 80 && u_host.got.size() < n; j++) begin
      @(posedge clock_in);
      #1;
    end
    if (u_host.got.size() < n) begin
      errors++;
      end_sim();
    end
    check("reply", e, n == 2 ? {u_host.got[0], u_host.got[1]}
                             : u_host.got[0]);
    check("reply done", 1'b0, tx_valid);
    @(posedge clock_in);
  endtask : query
  // kick pulses the data-in pin halfway through the pre-guard wait
  task automatic esc(input logic [7:0] ch, input int n, input logic m,
                     input bit kick = 1'b0);
    cyc(6 * TICK);
    din <= ~kick;
    cyc(4);
    din <= 1'b1;
    cyc(6 * TICK);
    repeat (n) u_host.send(ch, 1'b0);
    cyc(12 * TICK);
    check("command mode", m, cmd);
  endtask : esc
  initial begin
    repeat (100000) @(posedge clock_in);
    errors++;
    end_sim();
  end
  initial begin
    cyc(20);
    nrst_in <= 1'b1;
    cyc(12 * TICK);
    u_host.send(8'h41, 1'b0);
    esc(8'h2B, 3, 1'b0, 1'b1);
    esc(8'h2B, 2, 1'b0);
    check("data count", 16'h0006, 16'(dq.size()));
    for (i = 0; i < 6; i++) check("data", i ? 8'h2B : 8'h41, dq[i]);
    esc(8'h2B, 3, 1'b1);
    $display("test escape done");
    for (k = 0; k < 6; k++) query(codes[k], k < 3 ? 2 : 1, rv[k]);
    $display("test defaults done");
    for (k = 0; k < 5; k++) begin
      wr(8'h1F, 16'(k), 1'b0);
      wr(8'h28, 16'(k % 4), 1'b0);
      repeat (6) begin
        cts <= 1'($random(seed));
        txa <= 1'($random(seed));
        ind <= 1'($random(seed));
        cyc(3);
        #1;
        check("flow pin", flow_exp(k, cts, txa), flow_pin);
        check("ind pin", k % 4 ? k % 4 == 1 : ind, ind_pin);
        @(posedge clock_in);
      end
    end
    wr(8'h1F, 16'h0005, 1'b0);
    wr(8'h28, 16'h0004, 1'b0);
    wr(8'h04, 16'h0001, 1'b1);
    wr(8'h13, 16'h002A, 1'b0);
    wr(8'h13, 16'h001F, 1'b0);
    wr(8'h05, 16'h0003, 1'b1);
    query(8'h1F, 1, 16'h0004);
    query(8'h28, 1, 16'h0000);
    query(8'h04, 2, 16'h000A);
    query(8'h13, 1, 16'h002A);
    query(8'h05, 2, 16'h0003);
    $display("test settings done");
    u_host.send(8'h09, 1'b1);
    check("exit", 1'b0, cmd);
    esc(8'h2A, 3, 1'b1);
    wr(8'h06, 16'h0002, 1'b1);
    for (i = 0; i < 8 * TICK && cmd; i++) @(posedge clock_in);
    check("timeout", 1'b1, i >= TICK && i <= 4 * TICK);
    $display("test exit done");
    end_sim();
  end
endmodule : cme_top_test
`default_nettype wire
